// ==== core/pcs_cfg.svh ====
// constants for the link-2 / error-reporting configuration slice
// assumes byte addresses inside a 4 KB configuration space
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

// ************************************************************
// register offsets (byte addresses, dword aligned)
// ************************************************************
`define PCS_OFF_LINK2 12'h0f0
`define PCS_OFF_SLOT_CAP2 12'h0f4
`define PCS_OFF_SLOT2 12'h0f8
`define PCS_OFF_AER_HDR 12'h100
`define PCS_OFF_UNCOR_STS 12'h104

// ************************************************************
// link control 2 field layout and reset values
// ************************************************************
`define PCS_LC2_RST 16'h0002
`define PCS_LC2_WMASK 16'h1fbf
`define PCS_LC2_SPEED 3:0
`define PCS_LC2_COMPL 4
`define PCS_LC2_HWSPD 5
`define PCS_LC2_DEEMPH_SEL 6
`define PCS_LC2_MARGIN 9:7
`define PCS_LC2_MOD_COMPL 10
`define PCS_LC2_SOS 11
`define PCS_LC2_CDEEMPH 12
`define PCS_DEEMPH_UP 1'b0
`define PCS_DEEMPH_DOWN 1'b1

// ************************************************************
// error reporting header and uncorrectable status layout
// ************************************************************
`define PCS_AER_CAP_ID 16'h0001
`define PCS_AER_VERSION 4'h1
`define PCS_AER_NEXT 12'h140
`define PCS_UES_IMPL 32'h003ff011
`define PCS_UES_TRAIN 0
`define PCS_UES_DLP 4
`define PCS_UES_POISON 12
`define PCS_UES_FCP 13
`define PCS_UES_CPL_TO 14
`define PCS_UES_CPL_ABORT 15
`define PCS_UES_UNEXP_CPL 16
`define PCS_UES_RX_OVF 17
`define PCS_UES_MALFORMED 18
`define PCS_UES_ECRC 19
`define PCS_UES_UNSUP_REQ 20
`define PCS_UES_ACS 21

`endif

// ==== core/pcs_pkg.sv ====
// types shared by the configuration slice modules
// assumes pcs_cfg.svh is on the include path
package pcs_pkg;

    typedef enum logic {PCS_ST_STRAP, PCS_ST_RUN} pcs_phase_t;

    typedef struct packed {
        pcs_phase_t phase;
        logic downstream;
        logic deemph_sel;
        logic cur_deemph;
        logic tx_deemph;
        logic [31:0] rdata;
        logic rvalid;
    } pcs_main_t;

    typedef struct packed {
        logic [15:0] val;
    } pcs_field_t;

    typedef struct packed {
        logic [31:0] val;
    } pcs_sts_t;

    // expand byte enables to a bit mask
    function automatic logic [31:0] pcs_be_mask(input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return m;
    endfunction : pcs_be_mask

endpackage : pcs_pkg

// ==== core/pcs_rw_field.sv ====
// 16-bit software-writable field with per-bit write mask
// assumes writes arrive as single-cycle strobes with byte enables
`timescale 1ns/1ns
module pcs_rw_field import pcs_pkg::*; #(
    parameter logic [15:0] RST_VAL = 16'h0000,
    parameter logic [15:0] WMASK = 16'hffff
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [1:0] wr_be,
    input wire logic [15:0] wr_data,
    output logic [15:0] q
);
    pcs_field_t st_reg;
    pcs_field_t st_next;
    logic [31:0] bm;

    // only masked bits take write data; reserved bits keep their value
    always_comb begin
        bm = pcs_be_mask({2'b00, wr_be});
        st_next = st_reg;
        if (wr_en) begin
            st_next.val = (st_reg.val & ~(WMASK & bm[15:0])) | (wr_data & WMASK & bm[15:0]);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '{val: RST_VAL};
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.val;
endmodule : pcs_rw_field

// ==== core/pcs_w1c_status.sv ====
// sticky event status with write-one-to-clear
// assumes set inputs are one-cycle pulses from the event sources
`timescale 1ns/1ns
module pcs_w1c_status import pcs_pkg::*; #(
    parameter logic [31:0] IMPL = 32'hffffffff
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [31:0] set_vec,
    input wire logic clr_en,
    input wire logic [3:0] clr_be,
    input wire logic [31:0] clr_data,
    output logic [31:0] q
);
    pcs_sts_t st_reg;
    pcs_sts_t st_next;
    logic [31:0] clr_mask;

    // set is applied after clear so an event in the clearing cycle survives
    always_comb begin
        clr_mask = clr_en ? (clr_data & pcs_be_mask(clr_be)) : 32'h00000000;
        st_next.val = ((st_reg.val & ~clr_mask) | set_vec) & IMPL;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '{val: 32'h00000000};
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.val;
endmodule : pcs_w1c_status

// ==== core/pcs_link2_aer_regs.sv ====
// configuration registers: link control/status 2, slot 2 set,
// error reporting header and uncorrectable error status
// assumes config requests are decoded to one-cycle read/write strobes,
// and that event inputs are one-cycle pulses on mclk
`timescale 1ns/1ns
`include "pcs_cfg.svh"
module pcs_link2_aer_regs import pcs_pkg::*; (
    input wire logic mclk,
    input wire logic resetn,
    // port role strap, sampled once after reset release
    input wire logic port_is_downstream,
    // configuration access
    input wire logic cfg_wr_en,
    input wire logic cfg_rd_en,
    input wire logic [11:0] cfg_addr,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_rd_valid,
    // default preload from serial management or eeprom
    input wire logic preload_valid,
    input wire logic preload_deemph_sel,
    // de-emphasis level reported by the physical layer
    input wire logic link_deemph_update,
    input wire logic link_deemph_level,
    // error events from the link and transaction layers
    input wire logic event_training_err,
    input wire logic event_dl_protocol_err,
    input wire logic event_poisoned_tlp,
    input wire logic event_fc_protocol_err,
    input wire logic event_cpl_timeout,
    input wire logic event_completer_abort,
    input wire logic event_unexpected_cpl,
    input wire logic event_rx_overflow,
    input wire logic event_malformed_tlp,
    input wire logic event_ecrc_err,
    input wire logic event_unsupported_req,
    input wire logic event_acs_violation,
    // link control 2 settings toward the link logic
    output logic [3:0] link_target_speed,
    output logic link_enter_compliance,
    output logic hardware_speed_change_disable,
    output logic [2:0] link_tx_margin,
    output logic link_enter_mod_compliance,
    output logic compliance_skip_sets,
    output logic link_compliance_deemph,
    output logic link_tx_deemph
);

    // ************************************************************
    // state and decode
    // ************************************************************
    pcs_main_t st_reg;
    pcs_main_t st_next;
    logic [15:0] lc2_q;
    logic [31:0] ues_q;
    logic [31:0] ues_set;
    logic [15:0] lc2_view;
    logic [15:0] ls2_view;
    logic [31:0] aer_hdr;
    logic hit_link2;
    logic hit_ues;

    // dword compare; the low two address bits select bytes, not registers
    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
        return a[11:2] == off[11:2];
    endfunction : addr_hit

    assign hit_link2 = addr_hit(cfg_addr, `PCS_OFF_LINK2);
    assign hit_ues = addr_hit(cfg_addr, `PCS_OFF_UNCOR_STS);

    // ************************************************************
    // link control 2 writable fields
    // ************************************************************
    // upper half of the dword is status only, so only the low byte lanes reach it
    pcs_rw_field #(
        .RST_VAL(`PCS_LC2_RST),
        .WMASK(`PCS_LC2_WMASK)
    ) u_lc2 (
        .mclk(mclk),
        .resetn(resetn),
        .wr_en(cfg_wr_en && hit_link2),
        .wr_be(cfg_byte_en[1:0]),
        .wr_data(cfg_wdata[15:0]),
        .q(lc2_q)
    );

    // ************************************************************
    // uncorrectable error status
    // ************************************************************
    // gather event pulses into their status bit positions
    always_comb begin
        ues_set = 32'h00000000;
        ues_set[`PCS_UES_TRAIN] = event_training_err;
        ues_set[`PCS_UES_DLP] = event_dl_protocol_err;
        ues_set[`PCS_UES_POISON] = event_poisoned_tlp;
        ues_set[`PCS_UES_FCP] = event_fc_protocol_err;
        ues_set[`PCS_UES_CPL_TO] = event_cpl_timeout;
        ues_set[`PCS_UES_CPL_ABORT] = event_completer_abort;
        ues_set[`PCS_UES_UNEXP_CPL] = event_unexpected_cpl;
        ues_set[`PCS_UES_RX_OVF] = event_rx_overflow;
        ues_set[`PCS_UES_MALFORMED] = event_malformed_tlp;
        ues_set[`PCS_UES_ECRC] = event_ecrc_err;
        ues_set[`PCS_UES_UNSUP_REQ] = event_unsupported_req;
        ues_set[`PCS_UES_ACS] = event_acs_violation;
    end

    pcs_w1c_status #(
        .IMPL(`PCS_UES_IMPL)
    ) u_ues (
        .mclk(mclk),
        .resetn(resetn),
        .set_vec(ues_set),
        .clr_en(cfg_wr_en && hit_ues),
        .clr_be(cfg_byte_en),
        .clr_data(cfg_wdata),
        .q(ues_q)
    );

    // ************************************************************
    // read views
    // ************************************************************
    // select bit is not stored by the write field; it is spliced in here
    always_comb begin
        lc2_view = lc2_q;
        lc2_view[`PCS_LC2_DEEMPH_SEL] = st_reg.deemph_sel;
        ls2_view = 16'h0000;
        ls2_view[0] = st_reg.cur_deemph;
    end

    // constant capability header
    assign aer_hdr = {`PCS_AER_NEXT, `PCS_AER_VERSION, `PCS_AER_CAP_ID};

    // ************************************************************
    // main state update
    // ************************************************************
    // the strap is caught in the first cycle after reset release, since an
    // asynchronous reset may only load constants
    always_comb begin
        st_next = st_reg;
        st_next.rvalid = 1'b0;
        unique case (st_reg.phase)
            PCS_ST_STRAP: begin
                st_next.downstream = port_is_downstream;
                st_next.deemph_sel = port_is_downstream ? `PCS_DEEMPH_DOWN : `PCS_DEEMPH_UP;
                st_next.cur_deemph = port_is_downstream ? `PCS_DEEMPH_DOWN : `PCS_DEEMPH_UP;
                st_next.phase = PCS_ST_RUN;
            end
            PCS_ST_RUN: begin
                // preload replaces the default; software writes never reach it
                if (preload_valid) begin
                    st_next.deemph_sel = preload_deemph_sel;
                end
                if (link_deemph_update) begin
                    st_next.cur_deemph = link_deemph_level;
                end
            end
        endcase
        // upstream ports ignore the select bit and follow the negotiated level
        st_next.tx_deemph = st_next.downstream ? st_next.deemph_sel : st_next.cur_deemph;
        // one-cycle read answer; unmapped offsets read zero
        if (cfg_rd_en) begin
            st_next.rvalid = 1'b1;
            if (hit_link2) begin
                st_next.rdata = {ls2_view, lc2_view};
            end else if (addr_hit(cfg_addr, `PCS_OFF_SLOT_CAP2)) begin
                st_next.rdata = 32'h00000000;
            end else if (addr_hit(cfg_addr, `PCS_OFF_SLOT2)) begin
                st_next.rdata = 32'h00000000;
            end else if (addr_hit(cfg_addr, `PCS_OFF_AER_HDR)) begin
                st_next.rdata = aer_hdr;
            end else if (hit_ues) begin
                st_next.rdata = ues_q;
            end else begin
                st_next.rdata = 32'h00000000;
            end
        end
    end

    // reset state is the upstream role until the strap is sampled
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '{
                phase: PCS_ST_STRAP,
                downstream: 1'b0,
                deemph_sel: `PCS_DEEMPH_UP,
                cur_deemph: `PCS_DEEMPH_UP,
                tx_deemph: `PCS_DEEMPH_UP,
                rdata: 32'h00000000,
                rvalid: 1'b0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign cfg_rdata = st_reg.rdata;
    assign cfg_rd_valid = st_reg.rvalid;
    assign link_target_speed = lc2_q[`PCS_LC2_SPEED];
    assign link_enter_compliance = lc2_q[`PCS_LC2_COMPL];
    assign hardware_speed_change_disable = lc2_q[`PCS_LC2_HWSPD];
    assign link_tx_margin = lc2_q[`PCS_LC2_MARGIN];
    assign link_enter_mod_compliance = lc2_q[`PCS_LC2_MOD_COMPL];
    assign compliance_skip_sets = lc2_q[`PCS_LC2_SOS];
    assign link_compliance_deemph = lc2_q[`PCS_LC2_CDEEMPH];
    assign link_tx_deemph = st_reg.tx_deemph;

endmodule : pcs_link2_aer_regs

// ==== tb/pcs_regs_properties.sv ====
// concurrent checks on the link-2 / error-reporting register slice
// assumes binding to pcs_link2_aer_regs; sees only its ports
`timescale 1ns/1ns
module pcs_regs_properties (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic cfg_wr_en,
    input wire logic cfg_rd_en,
    input wire logic [11:0] cfg_addr,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rd_valid,
    input wire logic event_ecrc_err,
    input wire logic [3:0] link_target_speed,
    input wire logic [2:0] link_tx_margin
);
    // ************************************************************
    // helper terms and sequences
    // ************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    logic rd_ues;
    logic clr19;
    // a clear in the gap would hide the set, so it is excluded
    assign rd_ues = cfg_rd_en && cfg_addr == 12'h104;
    assign clr19 = cfg_wr_en && cfg_addr == 12'h104 && cfg_byte_en[2] && cfg_wdata[19];
    sequence s_ev_then_read;
        event_ecrc_err ##1 !clr19 ##1 rd_ues;
    endsequence
    sequence s_clr_then_read;
        (clr19 && !event_ecrc_err) ##1 !event_ecrc_err ##1 rd_ues;
    endsequence

    a_rdv_timing: assert property (cfg_rd_valid == $past(cfg_rd_en))
        else $error("read valid not one cycle after read");
    a_hdr_value: assert property (cfg_rd_en && cfg_addr == 12'h100 |=> cfg_rdata == 32'h14010001)
        else $error("error reporting header wrong");
    a_slot_zero: assert property (cfg_rd_en && cfg_addr[11:2] inside {10'h03d, 10'h03e} |=> cfg_rdata == 0)
        else $error("slot 2 registers not zero");
    a_unmapped_zero: assert property (cfg_rd_en && !(cfg_addr[11:2] inside {10'h03c, 10'h03d, 10'h03e, 10'h040,
        10'h041}) |=> cfg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_event_sets: assert property (s_ev_then_read |=> cfg_rdata[19])
        else $error("ecrc status bit not set");
    a_w1c_clears: assert property (s_clr_then_read |=> !cfg_rdata[19])
        else $error("status bit not cleared by one");
    a_speed_reset: assert property ($rose(resetn) |-> link_target_speed == 4'h2)
        else $error("target speed reset value wrong");
    a_speed_write: assert property (cfg_wr_en && cfg_addr == 12'h0f0 && cfg_byte_en[0]
        |=> link_target_speed == $past(cfg_wdata[3:0]))
        else $error("target speed not stored");
    a_margin_write: assert property (cfg_wr_en && cfg_addr == 12'h0f0 && cfg_byte_en[1:0] == 2'b11
        |=> link_tx_margin == $past(cfg_wdata[9:7]))
        else $error("transmit margin not stored");
endmodule : pcs_regs_properties

bind pcs_link2_aer_regs pcs_regs_properties u_props (.mclk(mclk), .resetn(resetn), .cfg_wr_en(cfg_wr_en),
    .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid), .event_ecrc_err(event_ecrc_err),
    .link_target_speed(link_target_speed), .link_tx_margin(link_tx_margin));

// ==== tb/pcs_host_model.sv ====
// host issuing configuration reads and writes on the strobe port
// assumes read data arrives one cycle after the read edge
`timescale 1ns/1ns
module pcs_host_model (
    input wire logic mclk,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rd_valid,
    output logic cfg_wr_en,
    output logic cfg_rd_en,
    output logic [11:0] cfg_addr,
    output logic [3:0] cfg_byte_en,
    output logic [31:0] cfg_wdata
);
    // ************************************************************
    // access tasks
    // ************************************************************
    initial begin
        cfg_wr_en = 1'b0;
        cfg_rd_en = 1'b0;
        cfg_addr = 12'h000;
        cfg_byte_en = 4'h0;
        cfg_wdata = 32'h0;
    end
    // status bits are cleared by writing ones; idle lines are inverted so stale data is never trusted
    task cfg_write(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge mclk);
        cfg_wr_en <= 1'b1;
        cfg_addr <= a;
        cfg_byte_en <= be;
        cfg_wdata <= d;
        @(posedge mclk);
        cfg_wr_en <= 1'b0;
        cfg_addr <= ~a;
        cfg_byte_en <= ~be;
        cfg_wdata <= ~d;
    endtask : cfg_write
    // data taken only in the cycle the valid pulse stands
    task cfg_read(input logic [11:0] a, output logic [31:0] d);
        @(posedge mclk);
        cfg_rd_en <= 1'b1;
        cfg_addr <= a;
        @(posedge mclk);
        cfg_rd_en <= 1'b0;
        cfg_addr <= ~a;
        // sample mid-cycle, while the registered answer stands settled
        @(negedge mclk);
        d = (cfg_rd_valid === 1'b1) ? cfg_rdata : 32'hxxxxxxxx;
    endtask : cfg_read
endmodule : pcs_host_model

// ==== tb/tb.sv ====
// self-checking bench for the link-2 / error-reporting registers
// assumes the host model drives the configuration port
`timescale 1ns/1ns
module tb;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic port_is_downstream = 1'b1;
    logic preload_valid = 1'b0;
    logic preload_deemph_sel = 1'b0;
    logic link_deemph_update = 1'b0;
    logic link_deemph_level = 1'b0;
    logic [11:0] evv = 12'h000;
    logic cfg_wr_en;
    logic cfg_rd_en;
    logic [11:0] cfg_addr;
    logic [3:0] cfg_byte_en;
    logic [31:0] cfg_wdata;
    logic [31:0] cfg_rdata;
    logic cfg_rd_valid;
    logic [3:0] link_target_speed;
    logic [2:0] link_tx_margin;
    logic link_tx_deemph;
    logic [4:0] lc_o;
    logic [31:0] rv;
    logic [31:0] ues;
    int n_fail = 0;
    int n_checks = 0;
    int bitpos [12] = '{0, 4, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21};

    always #5 mclk = ~mclk;

    pcs_host_model u_host (.mclk(mclk), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
        .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en),
        .cfg_wdata(cfg_wdata));

    pcs_link2_aer_regs uut (.mclk(mclk), .resetn(resetn), .port_is_downstream(port_is_downstream),
        .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
        .preload_valid(preload_valid), .preload_deemph_sel(preload_deemph_sel),
        .link_deemph_update(link_deemph_update), .link_deemph_level(link_deemph_level),
        .event_training_err(evv[0]), .event_dl_protocol_err(evv[1]), .event_poisoned_tlp(evv[2]),
        .event_fc_protocol_err(evv[3]), .event_cpl_timeout(evv[4]), .event_completer_abort(evv[5]),
        .event_unexpected_cpl(evv[6]), .event_rx_overflow(evv[7]), .event_malformed_tlp(evv[8]),
        .event_ecrc_err(evv[9]), .event_unsupported_req(evv[10]), .event_acs_violation(evv[11]),
        .link_target_speed(link_target_speed), .link_enter_compliance(lc_o[0]),
        .hardware_speed_change_disable(lc_o[1]), .link_tx_margin(link_tx_margin),
        .link_enter_mod_compliance(lc_o[2]), .compliance_skip_sets(lc_o[3]),
        .link_compliance_deemph(lc_o[4]), .link_tx_deemph(link_tx_deemph));

    // ************************************************************
    // helper tasks
    // ************************************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        u_host.cfg_read(a, rv);
        chk(rv, exp);
    endtask : rd_chk
    // strap is held through reset so the first edge after release sees it
    task do_reset(input logic down);
        @(posedge mclk);
        resetn <= 1'b0;
        port_is_downstream <= down;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask : do_reset
    task pulse_ev(input int i);
        @(posedge mclk);
        evv <= 12'h001 << i;
        @(posedge mclk);
        evv <= 12'h000;
    endtask : pulse_ev
    task pulse_deemph(input logic pre, input logic val);
        @(posedge mclk);
        preload_valid <= pre;
        preload_deemph_sel <= val;
        link_deemph_update <= !pre;
        link_deemph_level <= val;
        @(posedge mclk);
        preload_valid <= 1'b0;
        link_deemph_update <= 1'b0;
    endtask : pulse_deemph
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        do_reset(1'b1);
        rd_chk(12'h0f0, 32'h00010042);
        rd_chk(12'h0f4, 32'h0);
        rd_chk(12'h0f8, 32'h0);
        rd_chk(12'h100, 32'h14010001);
        rd_chk(12'h0ec, 32'h0);
        $display("reset values done");
        u_host.cfg_write(12'h0f0, 4'hf, 32'hffffffff);
        rd_chk(12'h0f0, 32'h00011fff);
        chk({29'h0, link_tx_margin}, 32'h7);
        chk({27'h0, lc_o}, 32'h1f);
        chk({28'h0, link_target_speed}, 32'hf);
        u_host.cfg_write(12'h0f0, 4'hf, 32'h0);
        rd_chk(12'h0f0, 32'h00010040);
        chk({27'h0, lc_o}, 32'h0);
        u_host.cfg_write(12'h100, 4'hf, 32'h0);
        rd_chk(12'h100, 32'h14010001);
        u_host.cfg_write(12'h0f8, 4'hf, 32'hffffffff);
        rd_chk(12'h0f8, 32'h0);
        $display("link control done");
        ues = 32'h0;
        foreach (bitpos[i]) begin
            pulse_ev(i);
            ues[bitpos[i]] = 1'b1;
            rd_chk(12'h104, ues);
        end
        u_host.cfg_write(12'h104, 4'hf, 32'h00001010);
        rd_chk(12'h104, 32'h003fe001);
        u_host.cfg_write(12'h104, 4'h0, 32'hffffffff);
        rd_chk(12'h104, 32'h003fe001);
        // a clear landing with a new event must not lose it
        fork
            u_host.cfg_write(12'h104, 4'hf, 32'h00080000);
            pulse_ev(9);
        join
        rd_chk(12'h104, 32'h003fe001);
        u_host.cfg_write(12'h104, 4'hf, 32'hffffffff);
        rd_chk(12'h104, 32'h0);
        pulse_ev(0);
        $display("error status done");
        do_reset(1'b0);
        rd_chk(12'h104, 32'h0);
        rd_chk(12'h0f0, 32'h00000002);
        chk({31'h0, link_tx_deemph}, 32'h0);
        pulse_deemph(1'b1, 1'b1);
        rd_chk(12'h0f0, 32'h00000042);
        chk({31'h0, link_tx_deemph}, 32'h0);
        pulse_deemph(1'b0, 1'b1);
        rd_chk(12'h0f0, 32'h00010042);
        chk({31'h0, link_tx_deemph}, 32'h1);
        do_reset(1'b1);
        chk({31'h0, link_tx_deemph}, 32'h1);
        pulse_deemph(1'b1, 1'b0);
        rd_chk(12'h0f0, 32'h00010002);
        chk({31'h0, link_tx_deemph}, 32'h0);
        $display("de-emphasis done");
        test_done();
    end

    // watchdog well beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done();
    end
endmodule : tb
